// >>> hw/pie_consts.vh
// Constants for the pulse input reference evaluator: map, codes, limits and timing.
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH
`define PIE_CLK_HZ 20000000
`define PIE_GATE_MS 100
`define PIE_GATES_PER_S 10
`define PIE_PWM_FMIN_HZ 50
`define PIE_PWM_FMAX_HZ 15000
`define PIE_AW 6
`define PIE_OFS_MODE 6'h00
`define PIE_OFS_OFFSET 6'h04
`define PIE_OFS_GAIN 6'h08
`define PIE_OFS_DIV 6'h0c
`define PIE_OFS_SCALE 6'h10
`define PIE_OFS_FMAX 6'h14
`define PIE_OFS_PMAX 6'h18
`define PIE_OFS_SRCSEL 6'h1c
`define PIE_OFS_PWM_ACT 6'h20
`define PIE_OFS_FREQ_ACT 6'h24
`define PIE_OFS_PCT_REF 6'h28
`define PIE_OFS_FREQ_REF 6'h2c
`define PIE_MODE_OFF 8'h00
`define PIE_MODE_PWM_UNI 8'h0a
`define PIE_MODE_PWM_BI 8'h0b
`define PIE_MODE_ONE_EDGE 8'h14
`define PIE_MODE_TWO_EDGE 8'h15
`define PIE_MODE_PULSE 8'h1e
`define PIE_SRC_THIS 8'h0a
`define PIE_OFFSET_MIN (-32'sd10000)
`define PIE_OFFSET_MAX 32'sd10000
`define PIE_OFFSET_RST 16'h0000
`define PIE_GAIN_MIN 32'd50
`define PIE_GAIN_MAX 32'd10000
`define PIE_GAIN_RST 16'h03e8
`define PIE_GAIN_UNITY 48'd1000
`define PIE_DIV_MIN 32'd1
`define PIE_DIV_MAX 32'd8192
`define PIE_DIV_RST 16'h0400
`define PIE_SCALE_MAX 32'd32000
`define PIE_SCALE_RST 16'h61a8
`define PIE_FMAX_RST 32'h00001388
`define PIE_PMAX_RST 16'h2710
`define PIE_FULL 16'h2710
`define PIE_FULL48 48'd10000
`define PIE_HZ_TO_CENTI 48'd100
`define PIE_OFFSET_LO16 16'hd8f0
`define PIE_OFFSET_HI16 16'h2710
`define PIE_GAIN_LO16 16'h0032
`define PIE_GAIN_HI16 16'h2710
`define PIE_DIV_LO16 16'h0001
`define PIE_DIV_HI16 16'h2000
`define PIE_SCALE_HI16 16'h7d00
`endif

// >>> hw/pie_div.v
// Serial restoring divider, one quotient bit per clock.
`timescale 1ns/10ps
`default_nettype none
module pie_div #(
  parameter W = 48
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [W-1:0] num,
  input wire [W-1:0] den,
  output reg done,
  output reg [W-1:0] quo
);
  reg [W-1:0] rem_q;
  reg [W-1:0] den_q;
  reg [W-1:0] n_q;
  reg [6:0] cnt_q;
  reg busy_q;
  localparam [31:0] STEPS = W;
  wire [W:0] trial = {rem_q, n_q[W-1]};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= {W{1'b0}};
      den_q <= {W{1'b0}};
      n_q <= {W{1'b0}};
      cnt_q <= 7'h00;
      busy_q <= 1'b0;
      done <= 1'b0;
      quo <= {W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        rem_q <= {W{1'b0}};
        den_q <= den;
        n_q <= num;
        cnt_q <= STEPS[6:0];
        busy_q <= 1'b1;
      end else if (busy_q) begin
        n_q <= {n_q[W-2:0], 1'b0};
        // A zero divisor yields all ones, which the caller clamps.
        if (trial >= {1'b0, den_q}) begin
          rem_q <= trial[W-1:0] - den_q;
          quo <= {quo[W-2:0], 1'b1};
        end else begin
          rem_q <= trial[W-1:0];
          quo <= {quo[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 7'h01;
        if (cnt_q == 7'h01) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // pie_div
`default_nettype wire

// >>> hw/pie_top.v
// Pulse input reference evaluator: PWM, edge-rate and pulse-train reference source.
// Notes on behaviour
// - Off selector code, the reset default, reports zero duty and zero frequency.
// - Code 10 measures duty, maps unipolar 0..100 percent of percent or frequency maximum.
// - Code 11 measures duty, maps bipolar -100..100 percent of either maximum.
// - Code 20 counts one edge polarity per period to find input rate.
// - Code 21 counts rising and falling edges to find input rate.
// - Code 30 scales pulse train so the scaling rate gives maximum frequency.
// - Pulse train mode also yields a percentage against the maximum percentage.
// - Any measuring code withholds the line from every other input function.
// - Duty is shifted by signed offset and multiplied by a clamped gain.
// - The adjusted PWM value, under code 11 mapped to -100..100 percent, is readable as an actual value.
// - PWM frequency equals percentage over 100 percent times maximum frequency.
// - Counted rate is divided by a 1..8192 divider, default 1024.
// - Measured rate or pulse train frequency is readable as an actual value.
// - Rate modes map 0..maximum frequency linearly onto 0..100 percent.
// - Either percentage source selector at code 10 takes this percentage.
// - Sign inversion of rate is left to the frequency channel downstream.
// - Scaling ranges 0..32000, default 25000; zero passes frequency unscaled.
// - Pulse reference equals input rate times maximum over scaling rate.
`timescale 1ns/10ps
`default_nettype none
`include "pie_consts.vh"
module pie_top #(
  parameter GATE_CYCLES = `PIE_CLK_HZ / 1000 * `PIE_GATE_MS,
  parameter PER_MAX = `PIE_CLK_HZ / `PIE_PWM_FMIN_HZ,
  parameter PER_MIN = (`PIE_CLK_HZ + `PIE_PWM_FMAX_HZ - 1) / `PIE_PWM_FMAX_HZ
) (
  input wire clk,
  input wire rst_b,
  input wire rate_input_line,
  input wire [`PIE_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire line_to_other_q,
  output reg signed [31:0] pct_ref_q,
  output reg signed [31:0] freq_ref_q,
  output wire signed [31:0] pct_src1_val,
  output wire signed [31:0] pct_src2_val
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg rst_m_q;
  reg rst_n_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // Pin synchroniser; the level moves only once stages two and three agree.
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;
  reg lvl_prev_q;
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else begin
      s1_q <= rate_input_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        lvl_q <= s3_q;
      lvl_prev_q <= lvl_q;
    end
  end
  wire rise = lvl_q & ~lvl_prev_q;
  wire fall = ~lvl_q & lvl_prev_q;

  // Configuration registers.
  reg [7:0] mode_q;
  reg signed [15:0] offset_q;
  reg [15:0] gain_q;
  reg [15:0] div_q;
  reg [15:0] scale_q;
  reg [31:0] fmax_q;
  reg [15:0] pmax_q;
  reg [7:0] src1_q;
  reg [7:0] src2_q;

  wire m_pwm = (mode_q == `PIE_MODE_PWM_UNI) || (mode_q == `PIE_MODE_PWM_BI);
  wire m_two = (mode_q == `PIE_MODE_TWO_EDGE);
  wire m_pulse = (mode_q == `PIE_MODE_PULSE);
  wire m_rate = (mode_q == `PIE_MODE_ONE_EDGE) || m_two || m_pulse;
  wire m_on = m_pwm || m_rate;
  assign line_to_other_q = m_on ? 1'b0 : lvl_q;

  wire req = avs_read | avs_write;
  reg ack_q;
  assign avs_waitrequest = req & ~ack_q;
  wire wr_go = avs_write & ack_q;
  wire signed [31:0] wsd = avs_writedata;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      mode_q <= `PIE_MODE_OFF;
      offset_q <= `PIE_OFFSET_RST;
      gain_q <= `PIE_GAIN_RST;
      div_q <= `PIE_DIV_RST;
      scale_q <= `PIE_SCALE_RST;
      fmax_q <= `PIE_FMAX_RST;
      pmax_q <= `PIE_PMAX_RST;
      src1_q <= `PIE_MODE_OFF;
      src2_q <= `PIE_MODE_OFF;
    end else begin
      ack_q <= req & ~ack_q;
      if (wr_go) begin
        case (avs_address)
          `PIE_OFS_MODE: mode_q <= avs_writedata[7:0];
          `PIE_OFS_OFFSET: begin
            // Settings outside the allowed span are pinned to its nearest end.
            if (wsd < `PIE_OFFSET_MIN)
              offset_q <= `PIE_OFFSET_LO16;
            else if (wsd > `PIE_OFFSET_MAX)
              offset_q <= `PIE_OFFSET_HI16;
            else
              offset_q <= wsd[15:0];
          end
          `PIE_OFS_GAIN: begin
            if (avs_writedata < `PIE_GAIN_MIN)
              gain_q <= `PIE_GAIN_LO16;
            else if (avs_writedata > `PIE_GAIN_MAX)
              gain_q <= `PIE_GAIN_HI16;
            else
              gain_q <= avs_writedata[15:0];
          end
          `PIE_OFS_DIV: begin
            if (avs_writedata < `PIE_DIV_MIN)
              div_q <= `PIE_DIV_LO16;
            else if (avs_writedata > `PIE_DIV_MAX)
              div_q <= `PIE_DIV_HI16;
            else
              div_q <= avs_writedata[15:0];
          end
          `PIE_OFS_SCALE: begin
            if (avs_writedata > `PIE_SCALE_MAX)
              scale_q <= `PIE_SCALE_HI16;
            else
              scale_q <= avs_writedata[15:0];
          end
          `PIE_OFS_FMAX: fmax_q <= avs_writedata;
          `PIE_OFS_PMAX: pmax_q <= avs_writedata[15:0];
          `PIE_OFS_SRCSEL: begin
            src1_q <= avs_writedata[7:0];
            src2_q <= avs_writedata[15:8];
          end
          default: ;
        endcase
      end
    end
  end

  // Timebase: PWM period and high time, and a fixed gate for edge counting.
  reg [31:0] per_cnt_q;
  reg [31:0] hi_cnt_q;
  reg [31:0] per_lat_q;
  reg [31:0] hi_lat_q;
  reg pwm_evt_q;
  reg [31:0] gate_q;
  reg [31:0] edge_q;
  reg [31:0] edge_lat_q;
  reg gate_evt_q;
  wire gate_end = (gate_q == GATE_CYCLES - 1);
  wire edge_hit = m_two ? (rise | fall) : rise;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      per_cnt_q <= 32'h00000000;
      hi_cnt_q <= 32'h00000000;
      per_lat_q <= 32'h00000000;
      hi_lat_q <= 32'h00000000;
      pwm_evt_q <= 1'b0;
      gate_q <= 32'h00000000;
      edge_q <= 32'h00000000;
      edge_lat_q <= 32'h00000000;
      gate_evt_q <= 1'b0;
    end else begin
      pwm_evt_q <= 1'b0;
      gate_evt_q <= 1'b0;
      if (rise || per_cnt_q == PER_MAX) begin
        // A line stuck for a whole slowest period reads as 0 or 100 percent.
        if (rise && per_cnt_q >= PER_MIN) begin
          per_lat_q <= per_cnt_q;
          hi_lat_q <= hi_cnt_q;
          pwm_evt_q <= m_pwm;
        end else if (!rise) begin
          per_lat_q <= per_cnt_q;
          hi_lat_q <= lvl_q ? per_cnt_q : 32'h00000000;
          pwm_evt_q <= m_pwm;
        end
        per_cnt_q <= 32'h00000001;
        hi_cnt_q <= {31'h0000000, lvl_q};
      end else begin
        per_cnt_q <= per_cnt_q + 32'h00000001;
        hi_cnt_q <= hi_cnt_q + {31'h0000000, lvl_q};
      end
      if (gate_end) begin
        gate_q <= 32'h00000000;
        edge_lat_q <= edge_q + {31'h0000000, edge_hit};
        edge_q <= 32'h00000000;
        gate_evt_q <= m_rate;
      end else begin
        gate_q <= gate_q + 32'h00000001;
        edge_q <= edge_q + {31'h0000000, edge_hit};
      end
    end
  end

  // Conversion sequence on the shared divider, one quotient per step.
  reg [1:0] st_q;
  reg [1:0] step_q;
  reg [15:0] duty_q;
  reg [15:0] adj_q;
  reg neg_q;
  reg signed [16:0] pct_q;
  reg [31:0] f_q;
  reg [47:0] op_num;
  reg [47:0] op_den;
  wire div_done;
  wire [47:0] quo;
  wire signed [17:0] shifted = $signed({2'b00, duty_q}) + offset_q;
  wire [17:0] shift_mag = shifted[17] ? -shifted : shifted;
  wire [16:0] pct_mag = pct_q[16] ? -pct_q : pct_q;
  wire [31:0] ebase = m_two ? {1'b0, edge_lat_q[31:1]} : edge_lat_q;
  wire [47:0] fin = ebase * `PIE_GATES_PER_S;
  wire [31:0] f_lim = (f_q > fmax_q) ? fmax_q : f_q;
  wire [47:0] q_sat = (quo > `PIE_FULL48) ? `PIE_FULL48 : quo;

  always @* begin
    op_num = 48'h000000000000;
    op_den = 48'h000000000001;
    case ({m_pwm, step_q})
      3'b100: begin
        op_num = hi_lat_q * `PIE_FULL48;
        op_den = {16'h0000, per_lat_q};
      end
      3'b101: begin
        op_num = shift_mag * gain_q;
        op_den = `PIE_GAIN_UNITY;
      end
      3'b110: begin
        op_num = pct_mag * pmax_q;
        op_den = `PIE_FULL48;
      end
      3'b111: begin
        op_num = pct_mag * fmax_q;
        op_den = `PIE_FULL48;
      end
      3'b000: begin
        if (m_pulse && scale_q != 16'h0000) begin
          op_num = fin * fmax_q;
          op_den = {32'h00000000, scale_q};
        end else if (m_pulse) begin
          op_num = fin * `PIE_HZ_TO_CENTI;
        end else begin
          op_num = fin * `PIE_HZ_TO_CENTI;
          op_den = {32'h00000000, div_q};
        end
      end
      3'b001: begin
        op_num = f_lim * `PIE_FULL48;
        op_den = {16'h0000, fmax_q};
      end
      3'b010: begin
        op_num = pct_mag * pmax_q;
        op_den = `PIE_FULL48;
      end
      default: ;
    endcase
  end

  pie_div #(
    .W(48)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n_q),
    .start(st_q == ST_RUN),
    .num(op_num),
    .den(op_den),
    .done(div_done),
    .quo(quo)
  );

  wire [31:0] q_lo = quo[31:0];
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      step_q <= 2'b00;
      duty_q <= 16'h0000;
      adj_q <= 16'h0000;
      neg_q <= 1'b0;
      pct_q <= 17'h00000;
      f_q <= 32'h00000000;
      pct_ref_q <= 32'h00000000;
      freq_ref_q <= 32'h00000000;
    end else if (!m_on) begin
      st_q <= ST_IDLE;
      step_q <= 2'b00;
      duty_q <= 16'h0000;
      adj_q <= 16'h0000;
      pct_q <= 17'h00000;
      f_q <= 32'h00000000;
      pct_ref_q <= 32'h00000000;
      freq_ref_q <= 32'h00000000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          step_q <= 2'b00;
          if ((m_pwm && pwm_evt_q) || (m_rate && gate_evt_q))
            st_q <= ST_RUN;
        end
        ST_RUN: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (div_done) begin
            st_q <= ST_RUN;
            step_q <= step_q + 2'b01;
            case ({m_pwm, step_q})
              3'b100: duty_q <= q_sat[15:0];
              3'b101: begin
                if (shifted[17])
                  adj_q <= 16'h0000;
                else
                  adj_q <= q_sat[15:0];
                if (mode_q == `PIE_MODE_PWM_BI)
                  pct_q <= $signed({q_sat[15:0], 1'b0}) - $signed({1'b0, `PIE_FULL});
                else
                  pct_q <= {1'b0, q_sat[15:0]};
                if (shifted[17] && mode_q == `PIE_MODE_PWM_BI)
                  pct_q <= -$signed({1'b0, `PIE_FULL});
                else if (shifted[17])
                  pct_q <= 17'h00000;
              end
              3'b110: pct_ref_q <= pct_q[16] ? -$signed(q_lo) : $signed(q_lo);
              3'b111: begin
                freq_ref_q <= pct_q[16] ? -$signed(q_lo) : $signed(q_lo);
                st_q <= ST_IDLE;
              end
              3'b000: f_q <= (quo[47:32] != 16'h0000) ? 32'hffffffff : q_lo;
              3'b001: pct_q <= {1'b0, q_sat[15:0]};
              3'b010: begin
                pct_ref_q <= $signed(q_lo);
                // Sign inversion, if wanted, happens in the frequency channel.
                freq_ref_q <= $signed(f_lim);
                st_q <= ST_IDLE;
              end
              default: st_q <= ST_IDLE;
            endcase
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign pct_src1_val = (src1_q == `PIE_SRC_THIS) ? pct_ref_q : 32'h00000000;
  assign pct_src2_val = (src2_q == `PIE_SRC_THIS) ? pct_ref_q : 32'h00000000;

  reg [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `PIE_OFS_MODE: rd_mux = {24'h000000, mode_q};
      `PIE_OFS_OFFSET: rd_mux = {{16{offset_q[15]}}, offset_q};
      `PIE_OFS_GAIN: rd_mux = {16'h0000, gain_q};
      `PIE_OFS_DIV: rd_mux = {16'h0000, div_q};
      `PIE_OFS_SCALE: rd_mux = {16'h0000, scale_q};
      `PIE_OFS_FMAX: rd_mux = fmax_q;
      `PIE_OFS_PMAX: rd_mux = {16'h0000, pmax_q};
      `PIE_OFS_SRCSEL: rd_mux = {16'h0000, src2_q, src1_q};
      `PIE_OFS_PWM_ACT: rd_mux = {{15{pct_q[16]}}, pct_q};
      `PIE_OFS_FREQ_ACT: rd_mux = f_q;
      `PIE_OFS_PCT_REF: rd_mux = pct_ref_q;
      `PIE_OFS_FREQ_REF: rd_mux = freq_ref_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_q)
      avs_readdata <= rd_mux;
  end
endmodule // pie_top
`default_nettype wire

// >>> bench/pie_chk.sv
// Concurrent checks on the ports of the pulse input reference evaluator.
`timescale 1ns/10ps
`default_nettype none
module pie_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rate_input_line,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic line_to_other_q,
  input wire logic signed [31:0] pct_ref_q,
  input wire logic signed [31:0] freq_ref_q,
  input wire logic signed [31:0] pct_src1_val,
  input wire logic signed [31:0] pct_src2_val
);
  logic [7:0] mode_q;
  logic [15:0] sel_q;
  logic mode_off;
  // Shadow copies of the mode and selector registers, updated when a write is accepted.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 8'h00;
      sel_q <= 16'h0000;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 6'h00) mode_q <= avs_writedata[7:0];
      if (avs_address == 6'h1c) sel_q <= avs_writedata[15:0];
    end
  end
  assign mode_off = !(mode_q == 8'h0a || mode_q == 8'h0b || mode_q == 8'h14 || mode_q == 8'h15 || mode_q == 8'h1e);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request not held off in its first cycle");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address >= 6'h30 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
  off_zero_a: assert property (mode_off [*2] |-> pct_ref_q == 32'sh0 && freq_ref_q == 32'sh0)
    else $error("references nonzero while evaluation is off");
  line_withheld_a: assert property (!mode_off |-> !line_to_other_q)
    else $error("line passed on while a measuring mode is selected");
  line_passed_a: assert property ((mode_off && $stable(rate_input_line)) [*8] |-> line_to_other_q == rate_input_line)
    else $error("line not passed on while evaluation is off");
  src_one_a: assert property (pct_src1_val == ((sel_q[7:0] == 8'h0a) ? pct_ref_q : 32'sh0))
    else $error("first percentage source wrong");
  src_two_a: assert property (pct_src2_val == ((sel_q[15:8] == 8'h0a) ? pct_ref_q : 32'sh0))
    else $error("second percentage source wrong");
endmodule // pie_chk
`default_nettype wire

// >>> bench/pie_src.sv
// Signal source model driving the rate input line with set high and low times.
`timescale 1ns/10ps
`default_nettype none
module pie_src (
  input wire logic clk,
  input wire logic en,
  input wire logic [15:0] hi_cycles,
  input wire logic [15:0] lo_cycles,
  output var logic line
);
  logic [15:0] cnt_q = 16'h0000;
  // Periods stay inside the band the duty measurement supports.
  always @(posedge clk) begin
    if (!en) begin
      line <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= (line ? hi_cycles : lo_cycles)) begin
      line <= !line;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // pie_src
`default_nettype wire

// >>> bench/pie_tb.sv
// Testbench for the pulse input reference evaluator.
`timescale 1ns/10ps
`default_nettype none
`include "pie_consts.vh"
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic src_en = 1'b0;
  logic [15:0] hi_c = 16'h00fa;
  logic [15:0] lo_c = 16'h02ee;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire line;
  wire avs_waitrequest;
  wire line_to_other_q;
  wire [31:0] avs_readdata;
  wire signed [31:0] pct_ref_q, freq_ref_q, pct_src1_val, pct_src2_val;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  pie_src u_src (.clk(clk), .en(src_en), .hi_cycles(hi_c), .lo_cycles(lo_c), .line(line));
  pie_top #(.GATE_CYCLES(2000), .PER_MAX(4000), .PER_MIN(100)) dut (.clk(clk), .rst_b(rst_b),
    .rate_input_line(line), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .line_to_other_q(line_to_other_q), .pct_ref_q(pct_ref_q), .freq_ref_q(freq_ref_q),
    .pct_src1_val(pct_src1_val), .pct_src2_val(pct_src2_val));
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  task check(input string nm, input logic signed [31:0] seen, input logic signed [31:0] exp, input int tol);
    samples_checked++;
    if ((^seen === 1'bx) || (seen > exp + tol) || (seen < exp - tol)) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  // Waitrequest and read data are read at the rising edge, before that edge's own updates land.
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rc(input string nm, input logic [5:0] a, input logic signed [31:0] e, input int t);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e, t);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rc("mode", `PIE_OFS_MODE, 32'h0, 0);
    rc("offset", `PIE_OFS_OFFSET, 32'h0, 0);
    rc("gain", `PIE_OFS_GAIN, 32'h3e8, 0);
    rc("divider", `PIE_OFS_DIV, 32'h400, 0);
    rc("scale", `PIE_OFS_SCALE, 32'h61a8, 0);
    rc("pwm_act", `PIE_OFS_PWM_ACT, 32'h0, 0);
    rc("freq_act", `PIE_OFS_FREQ_ACT, 32'h0, 0);
    wr(6'h30, 32'h5a5a);
    rc("unmapped", 6'h30, 32'h0, 0);
    $display("reset values done");
    wr(`PIE_OFS_OFFSET, 32'h4e20);
    rc("offset_hi", `PIE_OFS_OFFSET, 32'h2710, 0);
    wr(`PIE_OFS_OFFSET, 32'hffffb1e0);
    rc("offset_lo", `PIE_OFS_OFFSET, -32'sh2710, 0);
    wr(`PIE_OFS_GAIN, 32'h1);
    rc("gain_lo", `PIE_OFS_GAIN, 32'h32, 0);
    wr(`PIE_OFS_GAIN, 32'h4e20);
    rc("gain_hi", `PIE_OFS_GAIN, 32'h2710, 0);
    wr(`PIE_OFS_DIV, 32'h0);
    rc("div_lo", `PIE_OFS_DIV, 32'h1, 0);
    wr(`PIE_OFS_DIV, 32'h2328);
    rc("div_hi", `PIE_OFS_DIV, 32'h2000, 0);
    wr(`PIE_OFS_SCALE, 32'h9c40);
    rc("scale_hi", `PIE_OFS_SCALE, 32'h7d00, 0);
    wr(`PIE_OFS_PCT_REF, 32'h1234);
    rc("pct_ref_ro", `PIE_OFS_PCT_REF, 32'h0, 0);
    $display("limits done");
    wr(`PIE_OFS_OFFSET, 32'h0);
    wr(`PIE_OFS_GAIN, 32'h3e8);
    src_en <= 1'b1;
    wr(`PIE_OFS_MODE, 32'h0a);
    wr(`PIE_OFS_SRCSEL, 32'h0a0a);
    repeat (6000) @(posedge clk);
    rc("pwm_act", `PIE_OFS_PWM_ACT, 32'h9c4, 5);
    @(negedge clk);
    check("pct_ref", pct_ref_q, 32'h9c4, 5);
    check("freq_ref", freq_ref_q, 32'h4e2, 3);
    check("src1", pct_src1_val, 32'h9c4, 5);
    check("src2", pct_src2_val, 32'h9c4, 5);
    check("other", {31'h0, line_to_other_q}, 32'h0, 0);
    @(posedge clk);
    wr(`PIE_OFS_OFFSET, 32'h3e8);
    wr(`PIE_OFS_GAIN, 32'h7d0);
    repeat (6000) @(posedge clk);
    rc("pwm_adj", `PIE_OFS_PWM_ACT, 32'h1b58, 10);
    @(negedge clk);
    check("freq_adj", freq_ref_q, 32'hdac, 5);
    @(posedge clk);
    $display("unipolar done");
    wr(`PIE_OFS_OFFSET, 32'h0);
    wr(`PIE_OFS_GAIN, 32'h3e8);
    wr(`PIE_OFS_SRCSEL, 32'h000a);
    wr(`PIE_OFS_MODE, 32'h0b);
    repeat (6000) @(posedge clk);
    @(negedge clk);
    check("pct_bi", pct_ref_q, -32'sh1388, 10);
    check("freq_bi", freq_ref_q, -32'sh9c4, 5);
    check("src1_bi", pct_src1_val, -32'sh1388, 10);
    check("src2_off", pct_src2_val, 32'h0, 0);
    @(posedge clk);
    wr(`PIE_OFS_MODE, 32'h0);
    @(negedge clk);
    check("pct_off", pct_ref_q, 32'h0, 0);
    check("freq_off", freq_ref_q, 32'h0, 0);
    @(posedge clk);
    rc("pwm_off", `PIE_OFS_PWM_ACT, 32'h0, 0);
    $display("bipolar and off done");
    hi_c <= 16'h0032;
    lo_c <= 16'h0032;
    wr(`PIE_OFS_DIV, 32'h1);
    wr(`PIE_OFS_MODE, 32'h14);
    repeat (6200) @(posedge clk);
    rc("freq_act", `PIE_OFS_FREQ_ACT, 32'h4e20, 1000);
    @(negedge clk);
    check("freq_cap", freq_ref_q, 32'h1388, 0);
    check("pct_cap", pct_ref_q, 32'h2710, 0);
    check("other_rate", {31'h0, line_to_other_q}, 32'h0, 0);
    @(posedge clk);
    wr(`PIE_OFS_DIV, 32'h8);
    repeat (6200) @(posedge clk);
    @(negedge clk);
    check("freq_div", freq_ref_q, 32'h9c4, 130);
    check("pct_div", pct_ref_q, 32'h1388, 260);
    @(posedge clk);
    wr(`PIE_OFS_MODE, 32'h15);
    repeat (6200) @(posedge clk);
    @(negedge clk);
    check("freq_two", freq_ref_q, 32'h9c4, 130);
    check("pct_two", pct_ref_q, 32'h1388, 260);
    @(posedge clk);
    $display("edge count done");
    wr(`PIE_OFS_SCALE, 32'h190);
    wr(`PIE_OFS_MODE, 32'h1e);
    repeat (6200) @(posedge clk);
    @(negedge clk);
    check("freq_pulse", freq_ref_q, 32'h9c4, 130);
    check("pct_pulse", pct_ref_q, 32'h1388, 260);
    @(posedge clk);
    wr(`PIE_OFS_SCALE, 32'h0);
    wr(`PIE_OFS_PMAX, 32'h1388);
    repeat (6200) @(posedge clk);
    @(negedge clk);
    check("freq_raw", freq_ref_q, 32'h1388, 0);
    check("pct_pmax", pct_ref_q, 32'h1388, 0);
    $display("pulse train done");
    wrap_up();
  end
endmodule // testbench
bind pie_top pie_chk u_chk (.clk(clk), .rst_b(rst_b), .rate_input_line(rate_input_line),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_to_other_q(line_to_other_q),
  .pct_ref_q(pct_ref_q), .freq_ref_q(freq_ref_q), .pct_src1_val(pct_src1_val), .pct_src2_val(pct_src2_val));
`default_nettype wire
